// file: gtfc_timer.sv
// General-purpose down timer and free counter behind an Avalon-MM slave.
// Assumes a master that holds each request until waitrequest is low.
`timescale 1ns/1ps
module gtfc_timer
	import gtfc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [gtfc_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [gtfc_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [gtfc_pkg::BE_W-1:0] avs_byteenable,
	output logic [gtfc_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq
);
	// ==============================================================
	// Reset release
	logic rst_meta_q;
	logic rst_sync_n;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_n <= rst_meta_q;
		end
	end

	// ==============================================================
	// Free counter
	logic tick;
	logic [FREE_W-1:0] free_count;

	gtfc_free_counter u_free (
		.core_clk(core_clk),
		.rst_sync_n(rst_sync_n),
		.clk_en(clk_en),
		.tick(tick),
		.free_count(free_count)
	);

	// ==============================================================
	// Bus handshake
	// Every access costs one wait cycle while clk_en is high; reads sample on the first enabled edge
	logic ack_q;
	logic ack_d;
	logic req;
	logic wr_take;
	logic rd_sample;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic [FREE_W-1:0] snap_q;
	logic [FREE_W-1:0] snap_d;

	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~(ack_q & clk_en);
	assign wr_take = avs_write & ack_q;
	assign rd_sample = avs_read & ~ack_q;
	assign avs_readdata = rdata_q;

	// ==============================================================
	// Timer and interrupt state
	gtfc_run_t run_q;
	gtfc_run_t run_d;
	logic [PRELOAD_W-1:0] preload_q;
	logic [PRELOAD_W-1:0] preload_d;
	logic [PRELOAD_W-1:0] count_q;
	logic [PRELOAD_W-1:0] count_d;
	logic sts_q;
	logic sts_d;
	logic mask_q;
	logic mask_d;
	logic wrap_evt;
	logic wr_cfg;
	logic wr_sts;
	logic wr_mask;
	logic [DATA_W-1:0] cfg_view;

	assign wr_cfg = wr_take & (avs_address == OFS_TIMER_CONFIG);
	assign wr_sts = wr_take & (avs_address == OFS_IRQ_STATUS) & avs_byteenable[0];
	assign wr_mask = wr_take & (avs_address == OFS_IRQ_MASK) & avs_byteenable[0];
	assign cfg_view = {2'b00, run_q, 13'h0000, preload_q};

	// ==============================================================
	// Read path and snapshot
	always_comb begin
		ack_d = req & ~ack_q;
		rdata_d = rdata_q;
		snap_d = snap_q;
		if (rd_sample) begin
			case (avs_address)
				OFS_TIMER_CONFIG: rdata_d = cfg_view;
				OFS_TIMER_COUNT: rdata_d = {16'h0000, count_q};
				OFS_FREE_COUNT: begin
					// Low half present: renew; upper half alone: reuse
					if (avs_byteenable[1:0] != 2'b00) begin
						snap_d = free_count;
						rdata_d = free_count;
					end else begin
						rdata_d = snap_q;
					end
				end
				OFS_IRQ_STATUS: rdata_d = {31'h0000_0000, sts_q};
				OFS_IRQ_MASK: rdata_d = {31'h0000_0000, mask_q};
				default: rdata_d = DATA_ZERO;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ack_q <= 1'b0;
			rdata_q <= DATA_ZERO;
			snap_q <= FREE_RST;
		end else if (clk_en) begin
			ack_q <= ack_d;
			rdata_q <= rdata_d;
			snap_q <= snap_d;
		end
	end

	// ==============================================================
	// Timer control
	// Writes to the free counter offset fall through and change nothing
	always_comb begin
		run_d = run_q;
		preload_d = preload_q;
		count_d = count_q;
		wrap_evt = 1'b0;
		if (wr_cfg && avs_byteenable[3]) begin
			run_d = avs_writedata[RUN_BIT] ? GTFC_RUN : GTFC_HALT;
		end
		if (wr_cfg && avs_byteenable[0]) begin
			preload_d[7:0] = avs_writedata[7:0];
		end
		if (wr_cfg && avs_byteenable[1]) begin
			preload_d[15:8] = avs_writedata[15:8];
		end
		// Stop preset beats whatever preload came in with the same write
		if (run_q == GTFC_RUN && run_d == GTFC_HALT) begin
			preload_d = PRELOAD_RST;
		end
		unique case (run_q)
			GTFC_RUN: begin
				if (tick) begin
					if (count_q == 16'h0000) begin
						wrap_evt = 1'b1;
						count_d = preload_q;
					end else begin
						count_d = count_q - 16'h0001;
					end
				end
			end
			GTFC_HALT: begin
				// Held still; a start loads the preload first
				if (run_d == GTFC_RUN) begin
					count_d = preload_d;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			run_q <= GTFC_HALT;
			preload_q <= PRELOAD_RST;
			count_q <= COUNT_RST;
		end else if (clk_en) begin
			run_q <= run_d;
			preload_q <= preload_d;
			count_q <= count_d;
		end
	end

	// ==============================================================
	// Interrupt status and mask
	always_comb begin
		mask_d = wr_mask ? avs_writedata[IRQ_TIMER_BIT] : mask_q;
		// A new event wins over a clear in the same cycle
		sts_d = (sts_q & ~(wr_sts & avs_writedata[IRQ_TIMER_BIT])) | wrap_evt;
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sts_q <= 1'b0;
			mask_q <= 1'b0;
		end else if (clk_en) begin
			sts_q <= sts_d;
			mask_q <= mask_d;
		end
	end

	assign irq = sts_q & mask_q;

	// ==============================================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_sync_n);

	sequence s_cfg_write;
		avs_write && !avs_waitrequest && avs_address == OFS_TIMER_CONFIG;
	endsequence

	sequence s_free_low_read;
		avs_read && !ack_q && clk_en && avs_address == OFS_FREE_COUNT
			&& avs_byteenable[1:0] != 2'b00;
	endsequence

	sequence s_free_high_read;
		avs_read && !ack_q && clk_en && avs_address == OFS_FREE_COUNT
			&& avs_byteenable[1:0] == 2'b00;
	endsequence

	sequence s_wrap;
		clk_en && run_q == GTFC_RUN && tick && count_q == 16'h0000;
	endsequence

	a_run_start: assert property (s_cfg_write ##0 (avs_byteenable[3] && avs_writedata[RUN_BIT])
		|=> run_q == GTFC_RUN)
		else $error("run bit write did not start timer");
	a_halt_hold: assert property ((run_q == GTFC_HALT) ##1 (run_q == GTFC_HALT)
		|-> $stable(count_q))
		else $error("halted timer count moved");
	a_stop_preset: assert property ($fell(run_q) |-> preload_q == PRELOAD_RST)
		else $error("preload not preset on stop");
	a_preload_write: assert property (s_cfg_write ##0 (avs_byteenable == 4'h3)
		|=> preload_q == $past(avs_writedata[15:0]))
		else $error("preload write lost");
	a_count_read: assert property (avs_read && !avs_waitrequest
		&& avs_address == OFS_TIMER_COUNT |-> avs_readdata == {16'h0000, $past(count_q)})
		else $error("count read mismatch");
	a_wrap_reload: assert property (s_wrap |=> count_q == $past(preload_q) && sts_q)
		else $error("wrap did not reload and flag");
	// A mask write racing the event may lawfully keep the line low
	a_event_irq: assert property (s_wrap ##0 (mask_q && !wr_mask)
		|=> irq ##1 (irq || $past(wr_sts) || $past(wr_mask)))
		else $error("timer event did not raise irq");
	a_snap_take: assert property (s_free_low_read |=> snap_q == avs_readdata
		&& avs_readdata == $past(free_count))
		else $error("snapshot not coherent");
	a_snap_hold: assert property (s_free_high_read |=> avs_readdata == $past(snap_q)
		&& $stable(snap_q))
		else $error("upper half read changed snapshot");
	a_free_ro: assert property (avs_write && !avs_waitrequest
		&& avs_address == OFS_FREE_COUNT |=> $stable(snap_q) && $stable(preload_q))
		else $error("write to free counter had an effect");
endmodule : gtfc_timer

// file: gtfc_pkg.sv
// Constants, register map and types of the general timer and free counter.
// Assumes a 125 MHz core clock and a 32-bit Avalon-MM register port.
// How it works
// - Writing one to run bit 29 of timer configuration starts the timer.
// - Run bit zero halts the timer; its count holds still.
// - Run bit falling from one to zero forces the preload to FFFFh.
// - Preload is bits 15-0, read/write, resets FFFFh, feeds the timer.
// - Timer count register returns the live 16-bit count, read-only, resets FFFFh.
// - Running timer raises interrupt events repeatedly, spaced by preload plus one 25 MHz ticks.
// - Free counter is 32 bits, starts at zero, increments every 25 MHz tick.
// - Free counter wraps from maximum to zero and keeps counting.
// - First-half read snapshots all 32 free-counter bits at once.
// - Free counter is cleared within 160 ns of a reset.
// - Free counter runs in every power state, never gated by them; here it freezes whenever clk_en is low.
package gtfc_pkg;
	// ==============================================================
	// Bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;
	// ==============================================================
	// Register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h80;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h84;
	localparam logic [ADDR_W-1:0] OFS_TIMER_CONFIG = 8'h8C;
	localparam logic [ADDR_W-1:0] OFS_TIMER_COUNT = 8'h90;
	localparam logic [ADDR_W-1:0] OFS_FREE_COUNT = 8'h9C;
	// ==============================================================
	// Fields and reset values
	localparam int RUN_BIT = 29;
	localparam int PRELOAD_W = 16;
	localparam int FREE_W = 32;
	localparam int IRQ_TIMER_BIT = 0;
	localparam logic [PRELOAD_W-1:0] PRELOAD_RST = 16'hFFFF;
	localparam logic [PRELOAD_W-1:0] COUNT_RST = 16'hFFFF;
	localparam logic [FREE_W-1:0] FREE_RST = 32'h0000_0000;
	localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
	// ==============================================================
	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int FREE_PERIOD_NS = 40;
	localparam int FREE_DIV = (FREE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FREE_CLR_MAX_NS = 160;
	localparam int FREE_CLR_MAX_CYC = FREE_CLR_MAX_NS / CLK_PERIOD_NS;
	localparam int PRESC_W = 3;
	localparam logic [PRESC_W-1:0] PRESC_LAST = 3'(FREE_DIV - 1);
	localparam logic [PRESC_W-1:0] PRESC_ZERO = 3'h0;
	// ==============================================================
	// Types
	typedef enum logic {
		GTFC_HALT = 1'b0,
		GTFC_RUN = 1'b1
	} gtfc_run_t;
endpackage : gtfc_pkg

// file: gtfc_free_counter.sv
// Free-running 32-bit counter with its own 25 MHz tick prescaler.
// Assumes a synchronised active-low reset and the 125 MHz core clock.
`timescale 1ns/1ps
module gtfc_free_counter
	import gtfc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_sync_n,
	input wire logic clk_en,
	output logic tick,
	output logic [gtfc_pkg::FREE_W-1:0] free_count
);
	// ==============================================================
	// Prescaler and counter
	logic [PRESC_W-1:0] presc_q;
	logic [PRESC_W-1:0] presc_d;
	logic [FREE_W-1:0] count_q;
	logic [FREE_W-1:0] count_d;

	// Only clk_en gates this logic; while it is low, prescaler and counter freeze
	always_comb begin
		tick = (presc_q == PRESC_LAST);
		presc_d = tick ? PRESC_ZERO : presc_q + 3'h1;
		count_d = tick ? count_q + 32'h1 : count_q;
	end

	// Async clear lands at once, well inside the clearing window
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			presc_q <= PRESC_ZERO;
			count_q <= FREE_RST;
		end else if (clk_en) begin
			presc_q <= presc_d;
			count_q <= count_d;
		end
	end

	assign free_count = count_q;

	// ==============================================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_sync_n);

	a_free_step: assert property (clk_en && tick |=> count_q == $past(count_q) + 32'h1)
		else $error("free counter did not step on tick");
	a_free_wrap: assert property (clk_en && tick && count_q == 32'hFFFF_FFFF |=> count_q == FREE_RST)
		else $error("free counter did not wrap to zero");
	a_free_clear: assert property ($rose(rst_sync_n) |-> count_q == FREE_RST)
		else $error("free counter not clear after reset");
	a_tick_space: assert property (clk_en && tick |=> !tick)
		else $error("prescaler ticks too often");
endmodule : gtfc_free_counter

// file: gtfc_testbench.sv
// Self-checking bench of the general timer and free counter.
// Assumes gtfc_timer as top and the constants of gtfc_pkg.
`timescale 1ns/1ps
module testbench;
	import gtfc_pkg::*;
	// ==============================================================
	// Stimulus and model state
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [ADDR_W-1:0] adr = '0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [DATA_W-1:0] wd = '0;
	logic [BE_W-1:0] be = '0;
	logic [DATA_W-1:0] rdata;
	logic wait_rq;
	logic irq;
	logic [DATA_W-1:0] v;
	logic [DATA_W-1:0] s1;
	int fails = 0;
	int tests_run = 0;
	int cyc = 0;
	int p, t0, t1, c0, base;
	int m_pre = 16'hFFFF;
	gtfc_timer u_dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
		.avs_readdata(rdata), .avs_waitrequest(wait_rq), .irq(irq));
	initial begin
		forever #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
	end
	// Counts only enabled edges, so frozen spans drop out of expectations
	always @(posedge core_clk) begin
		if (clk_en) begin
			cyc <= cyc + 1;
		end
	end
	// ==============================================================
	// Tasks
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp,
		input string what);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Idle edge first, so no signal is assigned twice in one time step
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic [BE_W-1:0] b, output logic [DATA_W-1:0] q);
		@(posedge core_clk);
		adr <= a;
		wr <= w;
		rd <= ~w;
		wd <= d;
		be <= b;
		// Waitrequest and read data are taken at the same rising edge
		do @(posedge core_clk); while (wait_rq !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	task automatic wait_irq(output int t);
		for (int k = 0; k < 400 && irq !== 1'b1; k++) begin
			@(negedge core_clk);
		end
		t = cyc;
		check(irq, 1'b1, "irq");
	endtask : wait_irq
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		#(CLK_PERIOD_NS * 20000);
		fails++;
		end_sim();
	end
	// ==============================================================
	// Scenarios
	initial begin
		void'($urandom(72));
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		base = cyc;
		repeat (3) @(posedge core_clk);
		bus(0, OFS_TIMER_CONFIG, 0, 4'hF, v);
		check(v, 32'h0000FFFF, "config reset");
		bus(0, OFS_TIMER_COUNT, 0, 4'hF, v);
		check(v, 32'h0000FFFF, "count reset");
		bus(0, OFS_FREE_COUNT, 0, 4'hF, s1);
		check(s1 * 5 <= cyc - base + 5, 1'b1, "free after reset");
		// Free counter: write ignored, frozen span, upper half holds snapshot
		c0 = cyc;
		bus(1, OFS_FREE_COUNT, 32'h0, 4'hF, v);
		@(posedge core_clk);
		clk_en <= 1'b0;
		repeat (40) @(posedge core_clk);
		clk_en <= 1'b1;
		bus(0, OFS_FREE_COUNT, 0, 4'hC, v);
		check(v, s1, "free upper half");
		bus(0, OFS_FREE_COUNT, 0, 4'hF, v);
		check((v - s1) * 5 + 5 >= cyc - c0 && (v - s1) * 5 <= cyc - c0 + 5, 1'b1,
			"free delta");
		// Timer with interrupt enabled
		p = 3 + $urandom % 6;
		m_pre = p;
		bus(1, OFS_IRQ_MASK, 32'h1, 4'hF, v);
		bus(1, OFS_TIMER_CONFIG, (32'h1 << RUN_BIT) | p, 4'hF, v);
		bus(0, OFS_TIMER_CONFIG, 0, 4'hF, v);
		check(v, (32'h1 << RUN_BIT) | m_pre, "config run");
		bus(0, OFS_TIMER_COUNT, 0, 4'hF, v);
		check(v <= p, 1'b1, "count in range");
		wait_irq(t0);
		bus(0, OFS_IRQ_STATUS, 0, 4'hF, v);
		check(v, 32'h1, "status set");
		bus(1, OFS_IRQ_STATUS, 32'h1, 4'hF, v);
		@(negedge core_clk);
		check(irq, 1'b0, "irq cleared");
		wait_irq(t1);
		check(t1 - t0, (p + 1) * FREE_DIV, "period");
		// Masked: status still sets, line stays low
		bus(1, OFS_IRQ_MASK, 32'h0, 4'hF, v);
		bus(1, OFS_IRQ_STATUS, 32'h1, 4'hF, v);
		repeat ((p + 2) * FREE_DIV) @(posedge core_clk);
		check(irq, 1'b0, "irq masked");
		bus(0, OFS_IRQ_STATUS, 0, 4'hF, v);
		check(v, 32'h1, "status masked");
		// Halt forces preload, count holds, count register ignores writes
		bus(1, OFS_TIMER_CONFIG, $urandom & 32'hFFFF, 4'hF, v);
		m_pre = 16'hFFFF;
		bus(0, OFS_TIMER_CONFIG, 0, 4'hF, v);
		check(v, m_pre, "preload forced");
		bus(0, OFS_TIMER_COUNT, 0, 4'hF, s1);
		repeat (30) @(posedge core_clk);
		bus(1, OFS_TIMER_COUNT, 32'h0, 4'hF, v);
		bus(0, OFS_TIMER_COUNT, 0, 4'hF, v);
		check(v, s1, "count halted");
		// Byte lanes: preload bytes alone, then the run bit alone loads it
		m_pre = 32'h100 + ($urandom & 32'hFF);
		bus(1, OFS_TIMER_CONFIG, m_pre, 4'h3, v);
		bus(0, OFS_TIMER_CONFIG, 0, 4'hF, v);
		check(v, m_pre, "preload lanes");
		bus(0, OFS_TIMER_COUNT, 0, 4'hF, v);
		check(v, s1, "count not loaded");
		bus(1, OFS_TIMER_CONFIG, 32'h1 << RUN_BIT, 4'h8, v);
		bus(0, OFS_TIMER_COUNT, 0, 4'hF, v);
		check(v <= m_pre && v + 1 >= m_pre, 1'b1, "count loaded");
		bus(1, 8'hA0, 32'hFFFFFFFF, 4'hF, v);
		bus(0, 8'hA0, 0, 4'hF, v);
		check(v, DATA_ZERO, "unmapped");
		end_sim();
	end
endmodule : testbench
